// >>> rtl/qsio_pkg.sv
// Purpose: Shared constants, codes and carrier types of the four-line serial instruction port.
// Assumes: Word bit 0 of the processor is the most significant bit, vector index 11.
// Notes:   Device codes are six-bit values; the low bit selects the second group.

package qsio_pkg;

  // ---------------------------------------------------------------------------
  // Device codes and word layout
  // ---------------------------------------------------------------------------
  localparam logic [5:0] DEV_CODE_RESET = 6'h20;
  localparam int unsigned WORD_W        = 12;
  localparam int unsigned RX_DEPTH_DEF  = 32;
  localparam int unsigned AC_IE_BIT     = 0;
  localparam int unsigned AC_LINE_LSB   = 8;
  localparam int unsigned AC_ERR_LSB    = 10;
  localparam int unsigned AC_BASE_LSB   = 4;
  localparam int unsigned L3_LOOP_BIT   = 11;
  localparam int unsigned L3_RTS_BIT    = 10;
  localparam int unsigned L3_DTR_BIT    = 9;
  localparam int unsigned L3_SPEED_BIT  = 8;
  localparam int unsigned L3_SECTX_BIT  = 7;
  localparam logic [2:0]  FIXED_HS_RST  = 3'h7;

  // ---------------------------------------------------------------------------
  // Instruction codes
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    set_interrupt_enable_op = 3'h0,
    vectored_branch_op      = 3'h1,
    read_primary_status_op  = 3'h2,
    ring_skip_op            = 3'h3,
    transmit_load_op        = 3'h4,
    receive_pop_op          = 3'h5,
    clear_transmit_op       = 3'h6,
    first_unused_op         = 3'h7
  } first_op_t;

  typedef enum logic [2:0] {
    clear_device_op         = 3'h0,
    load_line3_control_op   = 3'h1,
    load_branch_base_op     = 3'h2,
    read_line3_status_op    = 3'h7
  } second_op_t;

  typedef enum logic [1:0] {
    ERR_NONE   = 2'h0,
    ERR_FRAME  = 2'h1,
    ERR_PARITY = 2'h2,
    ERR_FULL   = 2'h3
  } rx_err_t;

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic       valid;
    logic       frame_err;
    logic       parity_err;
    logic [1:0] line;
    logic [7:0] data;
  } rx_push_t;

  typedef struct packed {
    logic       load;
    logic [1:0] line;
    logic [7:0] data;
  } tx_req_t;

  typedef struct packed {
    logic              ac_load;
    logic [WORD_W-1:0] ac;
    logic              skip;
    logic              branch;
    logic [10:0]       branch_addr;
  } cpu_rsp_t;

endpackage

// >>> rtl/qsio_port.sv
// Purpose: Programmed-I/O instruction port of a four-line asynchronous serial controller.
// Assumes: Instruction strobe, word and receiver/transmitter signals are on CLK_I;
//          modem levels and the device code strap are pins and are synchronised.
// Notes:   Answers to an instruction appear one clock after it is taken.

module qsio_port
  import qsio_pkg::*;
#(
  parameter int unsigned RX_DEPTH = RX_DEPTH_DEF
) (
  // Clock and reset
  input  wire logic              CLK_I,
  input  wire logic              ARST_N_I,
  // Configuration straps
  input  wire logic [5:0]        DEV_CODE_I,
  // Processor instruction port
  input  wire logic              IOT_VALID_I,
  input  wire logic [5:0]        IOT_DEV_I,
  input  wire logic [2:0]        IOT_OP_I,
  input  wire logic [WORD_W-1:0] AC_I,
  output cpu_rsp_t               RSP_O,
  output logic                   INT_REQ_O,
  // Receiver and transmitter side
  input  rx_push_t               RX_I,
  input  wire logic [3:0]        TX_EMPTY_I,
  output tx_req_t                TX_O,
  output logic                   LOOPBACK_O,
  // Modem pins
  input  wire logic [3:0]        RING_I,
  input  wire logic [2:0]        CARRIER_I,
  input  wire logic              L3_CTS_I,
  input  wire logic              L3_DSR_I,
  input  wire logic              L3_SEC_RX_I,
  output logic [3:0]             RTS_O,
  output logic [3:0]             DTR_O,
  output logic                   L3_SPEED_O,
  output logic                   L3_SEC_TX_O
);

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  // All pin levels pass two flops before any logic reads them.
  // Reset loads the factory device code, so decode works at once.
  // A new strap value reaches decode two clocks after it settles.
  localparam int unsigned SYN_W = 16;

  logic [SYN_W-1:0] syn1_r;
  logic [SYN_W-1:0] syn2_r;

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      syn1_r <= {DEV_CODE_RESET, 10'h000};
      syn2_r <= {DEV_CODE_RESET, 10'h000};
    end else begin
      syn1_r <= {DEV_CODE_I, RING_I, CARRIER_I, L3_CTS_I, L3_DSR_I, L3_SEC_RX_I};
      syn2_r <= syn1_r;
    end
  end

  // Named views of the second synchroniser stage.
  wire [5:0] strap    = syn2_r[15:10];
  wire [3:0] ring_lv  = syn2_r[9:6];
  wire [2:0] carr_lv  = syn2_r[5:3];
  wire       cts_lv   = syn2_r[2];
  wire       dsr_lv   = syn2_r[1];
  wire       secrx_lv = syn2_r[0];

  // ---------------------------------------------------------------------------
  // Instruction decode
  // ---------------------------------------------------------------------------
  // Compares the operation field of a selected group with one code.
  function automatic logic op_hit(input logic       grp,
                                  input logic [2:0] op,
                                  input logic [2:0] code);
    return grp && (op == code);
  endfunction

  // The strap low bit is ignored: the first code is always even.
  wire [5:0] code_a = {strap[5:1], 1'b0};
  wire [5:0] code_b = {strap[5:1], 1'b1};
  wire       grp_a  = IOT_VALID_I && (IOT_DEV_I == code_a);
  wire       grp_b  = IOT_VALID_I && (IOT_DEV_I == code_b);

  // Codes of other devices and unused operations give no answer.
  wire op_ie     = op_hit(grp_a, IOT_OP_I, set_interrupt_enable_op);
  wire op_branch = op_hit(grp_a, IOT_OP_I, vectored_branch_op);
  wire op_stat_a = op_hit(grp_a, IOT_OP_I, read_primary_status_op);
  wire op_ring   = op_hit(grp_a, IOT_OP_I, ring_skip_op);
  wire op_txld   = op_hit(grp_a, IOT_OP_I, transmit_load_op);
  wire op_pop    = op_hit(grp_a, IOT_OP_I, receive_pop_op);
  wire op_clrtx  = op_hit(grp_a, IOT_OP_I, clear_transmit_op);
  wire op_clrdev = op_hit(grp_b, IOT_OP_I, clear_device_op);
  wire op_l3ctl  = op_hit(grp_b, IOT_OP_I, load_line3_control_op);
  wire op_base   = op_hit(grp_b, IOT_OP_I, load_branch_base_op);
  wire op_stat_b = op_hit(grp_b, IOT_OP_I, read_line3_status_op);

  // ---------------------------------------------------------------------------
  // State registers
  // ---------------------------------------------------------------------------
  // Interrupt enable, ring latches, receive flag, branch base, line 3 control.
  logic       ie_r;
  logic [2:0] ring_r;
  logic       rxf_r;
  logic [7:0] base_r;
  logic [4:0] l3ctl_r;

  // Flags and the oldest received word from the two helper modules.
  wire       txf;
  wire [1:0] tx_line;
  wire [WORD_W-1:0] rx_head;
  wire       rx_empty;
  wire       rx_full;

  // ---------------------------------------------------------------------------
  // Transmit side
  // ---------------------------------------------------------------------------
  // A branch serves a waiting transmitter before received words.
  // With neither flag set it gives no answer and the program falls through.
  wire branch_go = op_branch && (txf || rxf_r);
  wire tx_served = branch_go && txf;

  // A branch that serves a transmitter, or a clear transmit, releases the latch of the top line.
  qsio_tx_select u_tx_select (
    .clk_i      (CLK_I),
    .arst_n_i   (ARST_N_I),
    .tx_empty_i (TX_EMPTY_I),
    .clr_top_i  (tx_served || op_clrtx),
    .clr_all_i  (op_clrdev),
    .pending_o  (txf),
    .line_o     (tx_line)
  );

  // ---------------------------------------------------------------------------
  // Receive side
  // ---------------------------------------------------------------------------
  // Framing is reported over parity when both are seen.
  wire [1:0] push_err = RX_I.frame_err  ? ERR_FRAME  :
                        RX_I.parity_err ? ERR_PARITY : ERR_NONE;
  wire [WORD_W-1:0] push_word = {push_err, RX_I.line, RX_I.data};
  wire              pop_go    = op_pop && !rx_empty;

  // A push into a full store is dropped; the full error shows on the next pop.
  qsio_rx_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (RX_DEPTH)
  ) u_rx_fifo (
    .clk_i       (CLK_I),
    .arst_n_i    (ARST_N_I),
    .push_i      (RX_I.valid),
    .push_data_i (push_word),
    .pop_i       (pop_go),
    .flush_i     (op_clrdev),
    .head_o      (rx_head),
    .empty_o     (rx_empty),
    .full_o      (rx_full)
  );

  // A full store overrides whatever error the oldest word carries.
  wire [WORD_W-1:0] pop_word = rx_empty ? '0 :
                               rx_full  ? {ERR_FULL, rx_head[AC_ERR_LSB-1:0]} : rx_head;

  // ---------------------------------------------------------------------------
  // Status words
  // ---------------------------------------------------------------------------
  // Both status words are packed with processor bit 0 as the top bit.
  wire [WORD_W-1:0] status_a = {rx_full, 2'b00,
                                ring_r[0], ring_r[1], ring_r[2],
                                carr_lv[0], carr_lv[1], carr_lv[2],
                                txf, rxf_r, ie_r};
  wire [WORD_W-1:0] status_b = {cts_lv, l3ctl_r[3:0], carr_lv[2], secrx_lv, cts_lv,
                                dsr_lv, carr_lv[2], secrx_lv, ie_r};
  // Line 3 ring is a level only; lines 0 to 2 keep a latched ring.
  wire              ring_any = (|ring_r) || ring_lv[3];

  // ---------------------------------------------------------------------------
  // Answer to the processor
  // ---------------------------------------------------------------------------
  // The low three address bits give the flag served and the line.
  wire [10:0] branch_addr = tx_served ? {base_r, 1'b0, tx_line}
                                      : {base_r, 1'b1, rx_head[AC_LINE_LSB+:2]};

  // Each answer field is a one-clock pulse, all zero when nothing answers.
  cpu_rsp_t rsp_nxt;

  always_comb begin
    rsp_nxt = '0;
    if (op_branch) begin
      if (branch_go) begin
        rsp_nxt.ac_load     = 1'b1;
        rsp_nxt.ac          = {10'h000, branch_addr[1:0]};
        rsp_nxt.branch      = 1'b1;
        rsp_nxt.branch_addr = branch_addr;
      end
    end else if (op_stat_a) begin
      rsp_nxt.ac_load = 1'b1;
      rsp_nxt.ac      = status_a;
    end else if (op_ring) begin
      rsp_nxt.skip = ring_any;
    end else if (op_pop) begin
      rsp_nxt.ac_load = 1'b1;
      rsp_nxt.ac      = pop_word;
    end else if (op_stat_b) begin
      rsp_nxt.ac_load = 1'b1;
      rsp_nxt.ac      = status_b;
    end
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  // A ring that is still present wins over a skip that clears it.
  wire [2:0] ring_clr = (op_ring || op_clrdev) ? 3'h7 : 3'h0;

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ie_r    <= 1'b0;
      ring_r  <= 3'h0;
      rxf_r   <= 1'b0;
      base_r  <= 8'h00;
      l3ctl_r <= 5'h00;
    end else begin
      // Clear device drops the enable and the line 3 control word.
      if (op_clrdev) begin
        ie_r    <= 1'b0;
        l3ctl_r <= 5'h00;
      end else begin
        if (op_ie) begin
          ie_r <= AC_I[AC_IE_BIT];
        end
        if (op_l3ctl) begin
          l3ctl_r <= AC_I[L3_SECTX_BIT+:5];
        end
      end
      // The branch base is kept across a clear device.
      if (op_base) begin
        base_r <= AC_I[AC_BASE_LSB+:8];
      end
      ring_r <= (ring_r & ~ring_clr) | ring_lv[2:0];
      rxf_r  <= !rx_empty;
    end
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      // The interrupt request follows the flags one clock late.
      RSP_O     <= '0;
      INT_REQ_O <= 1'b0;
      TX_O      <= '0;
    end else begin
      RSP_O     <= rsp_nxt;
      INT_REQ_O <= ie_r && (txf || rxf_r);
      TX_O.load <= op_txld;
      TX_O.line <= AC_I[AC_LINE_LSB+:2];
      TX_O.data <= AC_I[7:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Modem outputs
  // ---------------------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      // Lines 0 to 2 keep send request and terminal ready asserted.
      // Line 3 follows the control word loaded by the second group.
      RTS_O       <= {1'b0, FIXED_HS_RST};
      DTR_O       <= {1'b0, FIXED_HS_RST};
      L3_SPEED_O  <= 1'b0;
      L3_SEC_TX_O <= 1'b0;
      LOOPBACK_O  <= 1'b0;
    end else begin
      RTS_O       <= {l3ctl_r[L3_RTS_BIT-L3_SECTX_BIT], FIXED_HS_RST};
      DTR_O       <= {l3ctl_r[L3_DTR_BIT-L3_SECTX_BIT], FIXED_HS_RST};
      L3_SPEED_O  <= l3ctl_r[L3_SPEED_BIT-L3_SECTX_BIT];
      L3_SEC_TX_O <= l3ctl_r[0];
      LOOPBACK_O  <= l3ctl_r[L3_LOOP_BIT-L3_SECTX_BIT];
    end
  end

endmodule

// >>> rtl/qsio_rx_fifo.sv
// Purpose: Receive word store, oldest word first.
// Assumes: A push while full is dropped; the caller reports that state.
// Notes:   Head word is combinational from the array.

module qsio_rx_fifo #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 32
) (
  // Clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       arst_n_i,
  // Control
  input  wire logic                       push_i,
  input  wire logic [WIDTH-1:0]           push_data_i,
  input  wire logic                       pop_i,
  input  wire logic                       flush_i,
  // State
  output logic      [WIDTH-1:0]           head_o,
  output logic                            empty_o,
  output logic                            full_o
);

  localparam int unsigned PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0]    wr_r;
  logic [PW-1:0]    rd_r;
  logic [PW:0]      cnt_r;

  wire do_push = push_i && !full_o;
  wire do_pop  = pop_i && !empty_o;

  assign empty_o = (cnt_r == '0);
  assign full_o  = (cnt_r == (PW+1)'(DEPTH));
  assign head_o  = mem_r[rd_r];

  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem_r[wr_r] <= push_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else if (flush_i) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (do_push) begin
        wr_r <= PW'(wr_r + 1'b1);
      end
      if (do_pop) begin
        rd_r <= PW'(rd_r + 1'b1);
      end
      cnt_r <= (PW+1)'(cnt_r + {{PW{1'b0}}, do_push} - {{PW{1'b0}}, do_pop});
    end
  end

endmodule

// >>> rtl/qsio_tx_select.sv
// Purpose: Per-line transmit-ready latches and the priority pick among them.
// Assumes: Transmitter empty levels come from logic on the same clock.
// Notes:   Line 0 has the highest priority; a new edge wins over a clear.

module qsio_tx_select (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  // Transmitter side
  input  wire logic [3:0] tx_empty_i,
  // Control
  input  wire logic       clr_top_i,
  input  wire logic       clr_all_i,
  // Result
  output logic            pending_o,
  output logic [1:0]      line_o
);

  logic [3:0] empty_d_r;
  logic [3:0] tbe_latch_r;
  logic [3:0] clr_mask;
  logic [3:0] rise;

  function automatic logic [1:0] prio_line(input logic [3:0] req);
    logic [1:0] l;
    l = 2'h3;
    for (int i = 3; i >= 0; i--) begin
      if (req[i]) begin
        l = 2'(i);
      end
    end
    return l;
  endfunction

  assign rise     = tx_empty_i & ~empty_d_r;
  assign clr_mask = clr_all_i ? 4'hf : (clr_top_i ? (4'h1 << line_o) : 4'h0);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      empty_d_r   <= 4'h0;
      tbe_latch_r <= 4'h0;
      pending_o   <= 1'b0;
      line_o      <= 2'h0;
    end else begin
      empty_d_r   <= tx_empty_i;
      tbe_latch_r <= (tbe_latch_r & ~clr_mask) | rise;
      pending_o   <= |tbe_latch_r;
      line_o      <= prio_line(tbe_latch_r);
    end
  end

endmodule

// >>> testbench/qsio_cpu_model.sv
// Purpose: Processor model issuing device instructions to the port.
// Assumes: One instruction per call, strobe high for one clock.
// Notes:   Released fields show the inverse of their last value.
module qsio_cpu_model
  import qsio_pkg::*;
(
  // Clock
  input  wire logic         clk_i,
  // Instruction strobe
  output logic              valid_o,
  output logic [5:0]        dev_o,
  output logic [2:0]        op_o,
  output logic [WORD_W-1:0] ac_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    valid_o = 1'b0;
    dev_o = 6'h3f;
    op_o = 3'h7;
    ac_o = '0;
  end
  task automatic peripheral_instruction(input logic [5:0] d, input logic [2:0] o, input logic [11:0] a);
    @(posedge clk_i);
    valid_o <= 1'b1;
    dev_o <= d;
    op_o <= o;
    ac_o <= a;
    @(posedge clk_i);
    valid_o <= 1'b0;
    dev_o <= ~d;
    op_o <= ~o;
    ac_o <= ~a;
    repeat (2) @(posedge clk_i);
  endtask
endmodule

// >>> testbench/qsio_port_chk.sv
// Purpose: Port checks for the serial instruction port.
// Assumes: The strap code stays steady while instructions run.
// Notes:   Bound to the port from the bench top.
module qsio_port_chk
  import qsio_pkg::*;
(
  // Clock, reset and strap
  input wire logic              CLK_I,
  input wire logic              ARST_N_I,
  input wire logic [5:0]        DEV_CODE_I,
  // Instruction port
  input wire logic              IOT_VALID_I,
  input wire logic [5:0]        IOT_DEV_I,
  input wire logic [2:0]        IOT_OP_I,
  input wire logic [WORD_W-1:0] AC_I,
  input wire cpu_rsp_t          RSP_O,
  input wire logic              INT_REQ_O,
  // Line side
  input wire tx_req_t           TX_O,
  input wire logic [3:0]        RTS_O,
  input wire logic [3:0]        DTR_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!ARST_N_I);
  wire ev = IOT_VALID_I && IOT_DEV_I == {DEV_CODE_I[5:1], 1'b0};
  wire od = IOT_VALID_I && IOT_DEV_I == {DEV_CODE_I[5:1], 1'b1};
  sequence ie_on_s;
    ev && IOT_OP_I == set_interrupt_enable_op && AC_I[AC_IE_BIT];
  endsequence
  sequence sta_rd_s;
    ev && IOT_OP_I == read_primary_status_op;
  endsequence
  fixed_hs_a: assert property (RTS_O[2:0] == 3'h7 && DTR_O[2:0] == 3'h7)
    else $error("fixed handshake dropped");
  tx_copy_a: assert property (ev && IOT_OP_I == transmit_load_op
    |=> TX_O == {1'b1, $past(AC_I[9:0])}) else $error("transmit word wrong");
  tx_cause_a: assert property (TX_O.load |-> $past(ev && IOT_OP_I == 3'h4))
    else $error("transmit without instruction");
  sta_word_a: assert property (sta_rd_s |=> RSP_O.ac_load && RSP_O.ac[10:9] == 2'h0)
    else $error("status word wrong");
  ie_read_a: assert property (ie_on_s ##1 !IOT_VALID_I [*3] ##1 sta_rd_s
    |=> RSP_O.ac[AC_IE_BIT]) else $error("enable not shown");
  irq_a: assert property (sta_rd_s
    |=> INT_REQ_O == (RSP_O.ac[0] && (RSP_O.ac[2] || RSP_O.ac[1])))
    else $error("interrupt request wrong");
  brn_form_a: assert property (RSP_O.branch |-> RSP_O.ac_load
    && RSP_O.ac == {10'h0, RSP_O.branch_addr[1:0]}
    && $past(ev && IOT_OP_I == vectored_branch_op)) else $error("branch wrong");
  skip_cause_a: assert property (RSP_O.skip |-> $past(ev && IOT_OP_I == 3'h3))
    else $error("skip without instruction");
  load_cause_a: assert property (RSP_O.ac_load |->
    $past(ev && IOT_OP_I inside {3'h1, 3'h2, 3'h5} || od && IOT_OP_I == 3'h7))
    else $error("word load without read");
  l3_ctrl_a: assert property (od && IOT_OP_I == load_line3_control_op
    |=> ##1 RTS_O[3] == $past(AC_I[L3_RTS_BIT], 2) && DTR_O[3] == $past(AC_I[L3_DTR_BIT], 2))
    else $error("line 3 control wrong");
endmodule

// >>> testbench/qsio_port_tb.sv
// Purpose: Self-checking bench of the serial instruction port.
// Assumes: Strap held at one code; answers come one clock after the strobe.
// Notes:   The driver queues expected answers; a monitor matches them.
module qsio_port_tb
  import qsio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [5:0] EV  = 6'h1a;
  localparam logic [5:0] OD  = 6'h1b;
  localparam cpu_rsp_t   SKP = 26'h1000;
  logic        clk, arst_n, valid, int_req, loopback, speed, sec_tx, ie;
  rx_push_t    rx;
  logic [3:0]  tx_empty, ring, rts, dtr;
  logic [2:0]  carrier, op;
  logic [5:0]  dev;
  logic [7:0]  base;
  logic [11:0] ac, w;
  logic [11:0] wq[$];
  cpu_rsp_t    rsp;
  cpu_rsp_t    rq[$];
  tx_req_t     tx;
  tx_req_t     tq[$];
  int          err_count, tests_run;
  qsio_cpu_model cpu (.clk_i(clk), .valid_o(valid), .dev_o(dev), .op_o(op), .ac_o(ac));
  qsio_port dut (
    .CLK_I(clk), .ARST_N_I(arst_n), .DEV_CODE_I(OD),
    .IOT_VALID_I(valid), .IOT_DEV_I(dev), .IOT_OP_I(op), .AC_I(ac),
    .RSP_O(rsp), .INT_REQ_O(int_req), .RX_I(rx), .TX_EMPTY_I(tx_empty),
    .TX_O(tx), .LOOPBACK_O(loopback), .RING_I(ring), .CARRIER_I(carrier),
    .L3_CTS_I(1'b0), .L3_DSR_I(1'b0), .L3_SEC_RX_I(1'b0), .RTS_O(rts),
    .DTR_O(dtr), .L3_SPEED_O(speed), .L3_SEC_TX_O(sec_tx)
  );
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ----------------------------------------
  // Checking
  // ----------------------------------------
  task automatic fail(input string m);
    err_count++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic cmp_rsp(input cpu_rsp_t g, input cpu_rsp_t e);
    tests_run++;
    if (g !== e) fail($sformatf("answer %h, want %h", g, e));
  endtask
  task automatic cmp_tx(input tx_req_t g, input tx_req_t e);
    tests_run++;
    if (g !== e) fail($sformatf("transmit %h, want %h", g, e));
  endtask
  task automatic cmp_lvl(input logic [11:0] g, input logic [11:0] e);
    tests_run++;
    if (g !== e) fail($sformatf("pins %h, want %h", g, e));
  endtask
  always @(negedge clk) begin
    if (rsp !== '0) begin
      if (rq.size() == 0) fail("answer with nothing pending");
      else cmp_rsp(rsp, rq.pop_front());
    end
    if (tx.load !== 1'b0) begin
      if (tq.size() == 0) fail("transmit with nothing pending");
      else cmp_tx(tx, tq.pop_front());
    end
  end
  task automatic tally_and_finish();
    if (rq.size() + tq.size() > 0) fail("answers missing");
    $display("checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Stimulus helpers
  // ----------------------------------------
  function automatic cpu_rsp_t rd(input logic [11:0] a);
    return {1'b1, a, 13'h0};
  endfunction
  function automatic cpu_rsp_t br(input logic [1:0] ln);
    return {1'b1, 10'h0, ln, 2'h1, base, 1'b0, ln};
  endfunction
  function automatic logic [11:0] sta(input logic f, input logic [2:0] rg, input logic t, r);
    return {f, 2'h0, rg, carrier[0], carrier[1], carrier[2], t, r, ie};
  endfunction
  task automatic peripheral_instruction(input logic [5:0] d, input logic [2:0] o, input logic [11:0] a,
                     input cpu_rsp_t e);
    if (e !== '0) rq.push_back(e);
    if (d == EV && o == transmit_load_op) tq.push_back({1'b1, a[9:0]});
    cpu.peripheral_instruction(d, o, a);
  endtask
  task automatic push(input logic fe, pe, input logic [9:0] d);
    @(posedge clk);
    rx <= {1'b1, fe, pe, d};
    wq.push_back({fe ? 2'h1 : pe ? 2'h2 : 2'h0, d});
    @(posedge clk);
    rx <= {1'b0, ~fe, ~pe, ~d};
  endtask
  task automatic pop_all();
    while (wq.size() > 0) begin
      w = wq.pop_front();
      peripheral_instruction(EV, receive_pop_op, 12'($urandom), rd(w));
    end
  endtask
  task automatic pins(input logic [11:0] e);
    @(negedge clk);
    cmp_lvl({rts, dtr, loopback, speed, sec_tx, 1'b0}, e);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  initial begin
    idle(60000);
    fail("run limit reached");
    tally_and_finish();
  end
  initial begin
    arst_n = 1'b0;
    rx = '0;
    tx_empty = '0;
    ring = '0;
    carrier = '0;
    ie = 1'b0;
    base = '0;
    err_count = 0;
    tests_run = 0;
    void'($urandom(82264));
    idle(4);
    arst_n <= 1'b1;
    idle(4);
    pins(12'h770);
    peripheral_instruction(6'h20, read_primary_status_op, 12'h0, '0);
    peripheral_instruction(EV, first_unused_op, 12'hfff, '0);
    peripheral_instruction(OD, 3'h5, 12'hfff, '0);
    carrier <= 3'($urandom);
    idle(4);
    peripheral_instruction(EV, read_primary_status_op, 12'($urandom), rd(sta(0, 3'h0, 0, 0)));
    peripheral_instruction(EV, set_interrupt_enable_op, 12'h001, '0);
    ie = 1'b1;
    peripheral_instruction(EV, read_primary_status_op, 12'h0, rd(sta(0, 3'h0, 0, 0)));
    ring <= 4'h3;
    idle(4);
    ring <= 4'h0;
    idle(4);
    peripheral_instruction(EV, read_primary_status_op, 12'h0, rd(sta(0, 3'h6, 0, 0)));
    peripheral_instruction(EV, ring_skip_op, 12'h0, SKP);
    peripheral_instruction(EV, ring_skip_op, 12'h0, '0);
    ring <= 4'h8;
    idle(4);
    peripheral_instruction(EV, ring_skip_op, 12'h0, SKP);
    ring <= 4'h0;
    base = 8'($urandom);
    peripheral_instruction(OD, load_branch_base_op, {base, 4'h0}, '0);
    tx_empty <= 4'h6;
    idle(4);
    peripheral_instruction(EV, read_primary_status_op, 12'h0, rd(sta(0, 3'h0, 1, 0)));
    peripheral_instruction(EV, vectored_branch_op, 12'h0, br(2'h1));
    peripheral_instruction(EV, vectored_branch_op, 12'h0, br(2'h2));
    peripheral_instruction(EV, vectored_branch_op, 12'h0, '0);
    tx_empty <= 4'he;
    idle(4);
    peripheral_instruction(EV, clear_transmit_op, 12'h0, '0);
    peripheral_instruction(EV, vectored_branch_op, 12'h0, '0);
    repeat (4) peripheral_instruction(EV, transmit_load_op, 12'($urandom), '0);
    for (int k = 0; k < 4; k++) push(k[1], k[0], 10'($urandom));
    idle(2);
    peripheral_instruction(EV, read_primary_status_op, 12'h0, rd(sta(0, 3'h0, 0, 1)));
    pop_all();
    peripheral_instruction(EV, receive_pop_op, 12'hfff, rd(12'h0));
    peripheral_instruction(EV, read_primary_status_op, 12'h0, rd(sta(0, 3'h0, 0, 0)));
    repeat (33) push(1'b0, 1'b0, 10'($urandom));
    void'(wq.pop_back());
    idle(2);
    peripheral_instruction(EV, read_primary_status_op, 12'h0, rd(sta(1, 3'h0, 0, 1)));
    wq[0][11:10] = ERR_FULL;
    pop_all();
    peripheral_instruction(EV, receive_pop_op, 12'h0, rd(12'h0));
    peripheral_instruction(OD, load_line3_control_op, 12'hf80, '0);
    pins(12'hffe);
    peripheral_instruction(OD, read_line3_status_op, 12'h0,
        rd({1'b0, 4'hf, carrier[2], 3'h0, carrier[2], 1'b0, ie}));
    peripheral_instruction(OD, clear_device_op, 12'h0, '0);
    pins(12'h770);
    idle(4);
    tally_and_finish();
  end
endmodule

bind qsio_port qsio_port_chk chk (
  .CLK_I(CLK_I), .ARST_N_I(ARST_N_I), .DEV_CODE_I(DEV_CODE_I),
  .IOT_VALID_I(IOT_VALID_I), .IOT_DEV_I(IOT_DEV_I), .IOT_OP_I(IOT_OP_I),
  .AC_I(AC_I), .RSP_O(RSP_O), .INT_REQ_O(INT_REQ_O), .TX_O(TX_O),
  .RTS_O(RTS_O), .DTR_O(DTR_O)
);
